// ### src/fdt_map.svh
// constants of the discovery-table reader: bit counts, limits, field places
`ifndef FDT_MAP_SVH
`define FDT_MAP_SVH

// ---------------------------------------------------------------
// command framing
// ---------------------------------------------------------------
`define FDT_CMD_OPCODE     8'hA5
`define FDT_CMD_LAST_BIT   5'h07
`define FDT_ADDR_LAST_BIT  5'h17
`define FDT_DUMMY_EXT      5'h08
`define FDT_DUMMY_QUAD     5'h0A

// ---------------------------------------------------------------
// table geometry, synchroniser stages and buffer depth
// ---------------------------------------------------------------
`define FDT_TABLE_AW       11
`define FDT_TABLE_LAST     11'h7FF
`define FDT_SYNC_STAGES    3
`define FDT_BUF_DEPTH      2

// ---------------------------------------------------------------
// first extended id byte fields and reset values
// ---------------------------------------------------------------
`define FDT_EDID_BP_BIT    5
`define FDT_EDID_XIP_BIT   4
`define FDT_EDID_PIN_BIT   3
`define FDT_EDID_RESET     8'h00
`define FDT_PIN_IDLE       2'h3 // released, out parked high

`endif

// ### src/fdt_pkg.sv
// types shared by the discovery-table reader files
package fdt_pkg;

  typedef enum logic [2:0] {
    FDT_ST_CMD,
    FDT_ST_ADDR,
    FDT_ST_DUMMY,
    FDT_ST_DATA,
    FDT_ST_IGNORE
  } fdt_state_e;

  // one two-way data line as seen from the device
  typedef struct packed {
    logic out;
    logic oe_n;
  } fdt_pin_s;

  typedef logic [7:0] fdt_byte_t;

endpackage

// ### src/fdt_table_rom.sv
// read-only discovery parameter table, registered read data
`include "fdt_map.svh"

module fdt_table_rom (
  input  wire logic                       clock,
  input  wire logic                       rd_en,
  input  wire logic [`FDT_TABLE_AW-1:0]   addr,
  output fdt_pkg::fdt_byte_t              data_reg
);

  // -------------------------------------------------------------
  // table contents
  // -------------------------------------------------------------
  function automatic fdt_pkg::fdt_byte_t table_byte(
    input logic [`FDT_TABLE_AW-1:0] a
  );
    fdt_pkg::fdt_byte_t v;
    v = 8'hFF;
    case (a)
      11'h000: v = 8'h53;
      11'h001: v = 8'h46;
      11'h002: v = 8'h44;
      11'h003: v = 8'h50;
      11'h004: v = 8'h00;
      11'h005: v = 8'h01;
      11'h006: v = 8'h00;
      11'h008: v = 8'h00;
      11'h009: v = 8'h00;
      11'h00A: v = 8'h01;
      11'h00B: v = 8'h09;
      11'h00C: v = 8'h30;
      11'h00D: v = 8'h00;
      11'h00E: v = 8'h00;
      11'h030: v = 8'hE5;
      11'h031: v = 8'h20;
      11'h032: v = 8'hF1;
      11'h037: v = 8'h07;
      11'h038: v = 8'h29;
      11'h039: v = 8'hEB;
      11'h03A: v = 8'h27;
      11'h03B: v = 8'h6B;
      11'h03C: v = 8'h08;
      11'h03D: v = 8'h3B;
      11'h03E: v = 8'h27;
      11'h03F: v = 8'hBB;
      11'h040: v = 8'hFF;
      11'h046: v = 8'h27;
      11'h047: v = 8'hBB;
      11'h04A: v = 8'h29;
      11'h04B: v = 8'hEB;
      11'h04C: v = 8'h0C;
      11'h04D: v = 8'h20;
      11'h04E: v = 8'h10;
      11'h04F: v = 8'hD8;
      11'h050: v = 8'h00;
      11'h051: v = 8'h00;
      11'h052: v = 8'h00;
      11'h053: v = 8'h00;
      default: v = 8'hFF;
    endcase
    return v;
  endfunction

  always_ff @(posedge clock) begin
    if (rd_en) begin
      data_reg <= table_byte(addr);
    end
  end

  a_sig_first: assert property (@(posedge clock)
    rd_en && addr == 11'h000 |=> data_reg == 8'h53)
    else $error("signature byte wrong");
  a_gap_ones: assert property (@(posedge clock)
    rd_en && addr >= 11'h010 && addr <= 11'h02F |=> data_reg == 8'hFF)
    else $error("gap byte not all ones");
  a_tail_ones: assert property (@(posedge clock)
    rd_en && addr >= 11'h054 |=> data_reg == 8'hFF)
    else $error("tail byte not all ones");

endmodule

// ### src/fdt_buf2.sv
// two-entry buffer with valid and ready on both sides
`include "fdt_map.svh"

module fdt_buf2 (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               clear,
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  fdt_pkg::fdt_byte_t      in_data,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output fdt_pkg::fdt_byte_t      out_data
);

  fdt_pkg::fdt_byte_t mem_reg [`FDT_BUF_DEPTH];
  logic               wr_ptr_reg;
  logic               rd_ptr_reg;
  logic [1:0]         count_reg;
  wire                push;
  wire                pop;

  assign in_ready  = count_reg != 2'h2;
  assign out_valid = count_reg != 2'h0;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || clear) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      count_reg  <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule

// ### src/fdt_reader.sv
// discovery-table read command: pin sampling, framing, byte output
`include "fdt_map.svh"

module fdt_reader (
  input  wire logic   clock,
  input  wire logic   rst,
  input  wire logic   serial_clock,
  input  wire logic   chip_select_n,
  input  wire logic   serial_io_line_0,
  input  wire logic   quad_protocol,
  input  wire logic   execute_in_place_not_required,
  input  wire logic   reset_pin_function,
  output fdt_pkg::fdt_pin_s serial_io_line_1,
  output fdt_pkg::fdt_byte_t ext_id_byte0
);

  // -------------------------------------------------------------
  // pin synchronisers: level changes once stages two and three agree
  // -------------------------------------------------------------
  wire  [2:0] pin_raw;
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] lvl_reg;
  logic [2:0] lvl_next;

  assign pin_raw = {serial_io_line_0, chip_select_n, serial_clock};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      assign lvl_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi]
                                                        : lvl_reg[gi];
      always_ff @(posedge clock) begin
        // stages start at the pin's idle level: no false select after reset
        if (rst) begin
          s1_reg[gi]  <= gi == 1;
          s2_reg[gi]  <= gi == 1;
          s3_reg[gi]  <= gi == 1;
          lvl_reg[gi] <= gi == 1;
        end else begin
          s1_reg[gi]  <= pin_raw[gi];
          s2_reg[gi]  <= s1_reg[gi];
          s3_reg[gi]  <= s2_reg[gi];
          lvl_reg[gi] <= lvl_next[gi];
        end
      end
    end
  endgenerate

  wire sck_rise = lvl_next[0] & ~lvl_reg[0];
  wire sck_fall = ~lvl_next[0] & lvl_reg[0];
  wire deselect = lvl_reg[1];
  wire din      = lvl_next[2];

  // -------------------------------------------------------------
  // command framing
  // -------------------------------------------------------------
  fdt_pkg::fdt_state_e        state_reg;
  fdt_pkg::fdt_state_e        state_next;
  logic [4:0]                 cnt_reg;
  logic [4:0]                 cnt_next;
  logic [23:0]                sh_reg;
  logic [`FDT_TABLE_AW-1:0]   ptr_reg;
  logic [`FDT_TABLE_AW-1:0]   ptr_next;

  wire [23:0] sh_in      = {sh_reg[22:0], din};
  wire        take       = sck_rise & ~deselect;
  wire [4:0]  dummy_last = quad_protocol ? 5'(`FDT_DUMMY_QUAD - 1)
                                         : 5'(`FDT_DUMMY_EXT - 1);
  wire        op_match   = sh_in[7:0] == `FDT_CMD_OPCODE;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (deselect) begin
      state_next = fdt_pkg::FDT_ST_CMD;
      cnt_next   = 5'h00;
    end else if (take) begin
      cnt_next = 5'(cnt_reg + 5'h01);
      case (state_reg)
        fdt_pkg::FDT_ST_CMD: begin
          if (cnt_reg == `FDT_CMD_LAST_BIT) begin
            cnt_next   = 5'h00;
            state_next = op_match ? fdt_pkg::FDT_ST_ADDR
                                  : fdt_pkg::FDT_ST_IGNORE;
          end
        end
        fdt_pkg::FDT_ST_ADDR: begin
          if (cnt_reg == `FDT_ADDR_LAST_BIT) begin
            cnt_next   = 5'h00;
            state_next = fdt_pkg::FDT_ST_DUMMY;
          end
        end
        fdt_pkg::FDT_ST_DUMMY: begin
          if (cnt_reg == dummy_last) begin
            cnt_next   = 5'h00;
            state_next = fdt_pkg::FDT_ST_DATA;
          end
        end
        default: cnt_next = cnt_reg;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= fdt_pkg::FDT_ST_CMD;
      cnt_reg   <= 5'h00;
      sh_reg    <= 24'h000000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (take) begin
        sh_reg <= sh_in;
      end
    end
  end

  // -------------------------------------------------------------
  // table fetch into the buffer
  // -------------------------------------------------------------
  logic                pend_reg;
  fdt_pkg::fdt_byte_t  rom_data;
  fdt_pkg::fdt_byte_t  buf_data;
  logic                buf_in_ready;
  logic                buf_valid;
  logic                load;

  wire fill_active = state_reg == fdt_pkg::FDT_ST_DUMMY ||
                     state_reg == fdt_pkg::FDT_ST_DATA;
  wire rd_en       = fill_active & buf_in_ready & ~pend_reg & ~deselect;
  wire addr_done   = take && state_reg == fdt_pkg::FDT_ST_ADDR &&
                     cnt_reg == `FDT_ADDR_LAST_BIT;

  // plain 11-bit increment: no burst-wrap length is consulted
  assign ptr_next = addr_done ? sh_in[`FDT_TABLE_AW-1:0]
                  : rd_en     ? `FDT_TABLE_AW'(ptr_reg + 1'b1)
                  : ptr_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      ptr_reg  <= '0;
      pend_reg <= 1'b0;
    end else begin
      ptr_reg  <= ptr_next;
      pend_reg <= rd_en;
    end
  end

  fdt_table_rom u_rom (
    .clock    (clock),
    .rd_en    (rd_en),
    .addr     (ptr_reg),
    .data_reg (rom_data)
  );

  // one read in flight at a time, so a push always finds room
  fdt_buf2 u_buf (
    .clock     (clock),
    .rst       (rst),
    .clear     (deselect),
    .in_valid  (pend_reg),
    .in_ready  (buf_in_ready),
    .in_data   (rom_data),
    .out_valid (buf_valid),
    .out_ready (load),
    .out_data  (buf_data)
  );

  // -------------------------------------------------------------
  // byte output on the falling serial clock
  // -------------------------------------------------------------
  logic [2:0]          obit_reg;
  fdt_pkg::fdt_byte_t  osh_reg;
  fdt_pkg::fdt_pin_s   pin_reg;

  wire shift_edge = sck_fall & ~deselect &
                    state_reg == fdt_pkg::FDT_ST_DATA;
  assign load     = shift_edge & (obit_reg == 3'h0) & buf_valid;

  always_ff @(posedge clock) begin
    if (rst || deselect) begin
      obit_reg <= 3'h0;
      osh_reg  <= 8'h00;
      pin_reg  <= `FDT_PIN_IDLE;
    end else if (load) begin
      obit_reg     <= 3'h1;
      osh_reg      <= {buf_data[6:0], 1'b0};
      pin_reg.out  <= buf_data[7];
      pin_reg.oe_n <= 1'b0;
    end else if (shift_edge && obit_reg != 3'h0) begin
      obit_reg    <= 3'(obit_reg + 3'h1);
      osh_reg     <= {osh_reg[6:0], 1'b0};
      pin_reg.out <= osh_reg[7];
    end
  end

  assign serial_io_line_1 = pin_reg;

  // -------------------------------------------------------------
  // first extended id byte
  // -------------------------------------------------------------
  fdt_pkg::fdt_byte_t edid_next;

  always_comb begin
    edid_next = `FDT_EDID_RESET;
    edid_next[`FDT_EDID_BP_BIT]  = 1'b0;
    edid_next[`FDT_EDID_XIP_BIT] = execute_in_place_not_required;
    edid_next[`FDT_EDID_PIN_BIT] = reset_pin_function;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ext_id_byte0 <= `FDT_EDID_RESET;
    end else begin
      ext_id_byte0 <= edid_next;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  logic [4:0] dummy_seen_reg;

  always_ff @(posedge clock) begin
    if (rst || state_reg != fdt_pkg::FDT_ST_DUMMY) begin
      dummy_seen_reg <= 5'h00;
    end else if (take) begin
      dummy_seen_reg <= 5'(dummy_seen_reg + 5'h01);
    end
  end

  sequence s_addr_end;
    addr_done;
  endsequence

  a_deselect_release: assert property (@(posedge clock) disable iff (rst)
    deselect |=> serial_io_line_1.oe_n)
    else $error("line still driven after deselect");
  a_dummy_count: assert property (@(posedge clock) disable iff (rst)
    state_reg == fdt_pkg::FDT_ST_DUMMY && state_next ==
    fdt_pkg::FDT_ST_DATA |-> dummy_seen_reg == dummy_last)
    else $error("wrong number of dummy clocks");
  a_quiet_before: assert property (@(posedge clock) disable iff (rst)
    state_reg != fdt_pkg::FDT_ST_DATA |=> serial_io_line_1.oe_n)
    else $error("line driven before data phase");
  a_start_address: assert property (@(posedge clock) disable iff (rst)
    s_addr_end |=> ptr_reg == $past(sh_in[10:0]))
    else $error("start address not taken");
  a_ptr_step: assert property (@(posedge clock) disable iff (rst)
    rd_en && !deselect |=> ptr_reg == 11'($past(ptr_reg) + 11'h001))
    else $error("pointer did not step");
  a_ptr_wrap: assert property (@(posedge clock) disable iff (rst)
    rd_en && ptr_reg == `FDT_TABLE_LAST |=> ptr_reg == 11'h000)
    else $error("pointer did not wrap");
  a_msb_first: assert property (@(posedge clock) disable iff (rst)
    load |=> serial_io_line_1.out == $past(buf_data[7]) &&
    !serial_io_line_1.oe_n)
    else $error("first bit is not the msb");
  a_shift_fall: assert property (@(posedge clock) disable iff (rst)
    !shift_edge && !deselect |=> $stable(serial_io_line_1))
    else $error("output moved off a falling clock edge");
  a_foreign_quiet: assert property (@(posedge clock) disable iff (rst)
    state_reg == fdt_pkg::FDT_ST_IGNORE |-> serial_io_line_1.oe_n)
    else $error("driven on a foreign opcode");
  a_edid_fields: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> ext_id_byte0[5] == 1'b0 &&
    ext_id_byte0[4] == $past(execute_in_place_not_required) &&
    ext_id_byte0[3] == $past(reset_pin_function))
    else $error("extended id fields wrong");
  a_rise_sample: assert property (@(posedge clock) disable iff (rst)
    take |=> sh_reg[0] == $past(din))
    else $error("input bit not sampled on rise");

endmodule

// ### verification/fdt_host_model.sv
// spi host model that clocks discovery-table reads through the reader
module fdt_host_model (
  output logic              serial_clock,
  output logic              chip_select_n,
  output logic              serial_io_line_0,
  input  fdt_pkg::fdt_pin_s serial_io_line_1
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_level;
  logic wire_level;

  // ---------------------------------------------------------------
  // released line shows the inverse of its last driven level
  // ---------------------------------------------------------------
  initial begin
    last_level = 1'b0;
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
    serial_io_line_0 = 1'b0;
  end

  always @(serial_io_line_1) begin
    if (serial_io_line_1.oe_n === 1'b0) last_level = serial_io_line_1.out;
  end

  assign wire_level = (serial_io_line_1.oe_n === 1'b0) ?
                      serial_io_line_1.out : ~last_level;

  // ---------------------------------------------------------------
  // link cycles: mode 0, clock stands low outside frames
  // ---------------------------------------------------------------
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      serial_io_line_0 = ~serial_io_line_0;
      #100 serial_clock = 1'b1;
      #100 serial_clock = 1'b0;
    end
  endtask

  task automatic start_read(input logic [7:0] op, input logic [23:0] addr,
                            input int dummies);
    logic [31:0] v;
    v = {op, addr};
    chip_select_n = 1'b0;
    #100;
    for (int i = 31; i >= 0; i--) begin
      serial_io_line_0 = v[i];
      #100 serial_clock = 1'b1;
      #100 serial_clock = 1'b0;
    end
    pulse(dummies);
  endtask

  // sample late in the high phase: sync delay in the device is long
  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serial_io_line_0 = ~serial_io_line_0;
      #100 serial_clock = 1'b1;
      #95 b[i] = wire_level;
      #5 serial_clock = 1'b0;
    end
  endtask

  task automatic stop();
    #100 chip_select_n = 1'b1;
    #400;
  endtask
endmodule

// ### verification/flash_discovery_table_reader_tb.sv
// self-checking bench for the discovery-table reader
`include "fdt_map.svh"

module flash_discovery_table_reader_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clock;
  logic               rst;
  logic               quad_protocol;
  logic               xip_nr;
  logic               pin_fn;
  logic               serial_clock;
  logic               chip_select_n;
  logic               serial_io_line_0;
  fdt_pkg::fdt_pin_s  serial_io_line_1;
  fdt_pkg::fdt_byte_t ext_id_byte0;
  int                 failures;
  int                 tests_run;
  logic [7:0]         b;

  fdt_reader dut_u (
    .clock                         (clock),
    .rst                           (rst),
    .serial_clock                  (serial_clock),
    .chip_select_n                 (chip_select_n),
    .serial_io_line_0              (serial_io_line_0),
    .quad_protocol                 (quad_protocol),
    .execute_in_place_not_required (xip_nr),
    .reset_pin_function            (pin_fn),
    .serial_io_line_1              (serial_io_line_1),
    .ext_id_byte0                  (ext_id_byte0)
  );

  fdt_host_model host_u (
    .serial_clock     (serial_clock),
    .chip_select_n    (chip_select_n),
    .serial_io_line_0 (serial_io_line_0),
    .serial_io_line_1 (serial_io_line_1)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // comparison, verdict, expected table
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [7:0] exp_byte(input logic [10:0] a);
    case (a)
      11'h000: return 8'h53;
      11'h001: return 8'h46;
      11'h002: return 8'h44;
      11'h003: return 8'h50;
      11'h004, 11'h006, 11'h008, 11'h009, 11'h00D, 11'h00E,
      11'h050, 11'h051, 11'h052, 11'h053: return 8'h00;
      11'h005, 11'h00A: return 8'h01;
      11'h00B: return 8'h09;
      11'h00C: return 8'h30;
      11'h030: return 8'hE5;
      11'h031, 11'h04D: return 8'h20;
      11'h032: return 8'hF1;
      11'h037: return 8'h07;
      11'h038, 11'h04A: return 8'h29;
      11'h039, 11'h04B: return 8'hEB;
      11'h03A, 11'h03E, 11'h046: return 8'h27;
      11'h03B: return 8'h6B;
      11'h03C: return 8'h08;
      11'h03D: return 8'h3B;
      11'h03F, 11'h047: return 8'hBB;
      11'h04C: return 8'h0C;
      11'h04E: return 8'h10;
      11'h04F: return 8'hD8;
      default: return 8'hFF;
    endcase
  endfunction

  task automatic wait_release();
    int k;
    k = 0;
    while (serial_io_line_1.oe_n !== 1'b1 && k < 40) begin
      @(negedge clock);
      k++;
    end
    check({7'h00, serial_io_line_1.oe_n}, 8'h01);
    if (k == 40) test_done();
  endtask

  task automatic read_run(input logic [23:0] addr, input int n,
                          input int dummies);
    logic [10:0] a;
    a = addr[10:0];
    host_u.start_read(`FDT_CMD_OPCODE, addr, dummies);
    for (int i = 0; i < n; i++) begin
      host_u.get_byte(b);
      check(b, exp_byte(a));
      a = a + 11'h001;
    end
    host_u.stop();
    wait_release();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_table();
    read_run(24'h000000, 84, `FDT_DUMMY_EXT);
  endtask

  // upper address bits set, run across the end of the table
  task automatic t_wrap();
    read_run(24'hA5F7FD, 5, `FDT_DUMMY_EXT);
  endtask

  task automatic t_quad();
    @(negedge clock) quad_protocol = 1'b1;
    read_run(24'h000038, 4, `FDT_DUMMY_QUAD);
    @(negedge clock) quad_protocol = 1'b0;
  endtask

  task automatic t_refuse();
    host_u.start_read(8'h5A, 24'h000000, `FDT_DUMMY_EXT);
    host_u.pulse(12);
    check({7'h00, serial_io_line_1.oe_n}, 8'h01);
    host_u.stop();
  endtask

  // select rises mid-byte, then a fresh read must start clean
  task automatic t_abort();
    host_u.start_read(`FDT_CMD_OPCODE, 24'h000030, `FDT_DUMMY_EXT);
    host_u.pulse(3);
    host_u.stop();
    wait_release();
    read_run(24'h000004, 2, `FDT_DUMMY_EXT);
  endtask

  task automatic t_ext();
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      xip_nr = i[1];
      pin_fn = i[0];
      repeat (3) @(negedge clock);
      check(ext_id_byte0, {3'h0, i[1], i[0], 3'h0});
    end
  endtask

  initial begin
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    quad_protocol = 1'b0;
    xip_nr = 1'b0;
    pin_fn = 1'b0;
    repeat (16) @(negedge clock);
    check(ext_id_byte0, 8'h00);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    t_table();
    t_wrap();
    t_quad();
    t_refuse();
    t_abort();
    t_ext();
    test_done();
  end
endmodule
